/* rtl/sdd_top.v */
//
// Functional notes
// - Each channel decimates its one-bit stream with a cubed sinc comb.
// - Every oversampling period an enabled channel writes one new result.
// - Source, divider and ratio set modulator rate and first notch.
// - Aligned step valid on third result, unaligned one result later.
// - Filter output width grows from 15 to 24 bits with ratio.
// - Ratio 256 with low-bit access shows filter bits 23 to 8.
// - Ratio 32 word read LSB always reads zero.
// - Low-bit access word read below ratio 256 returns the 16 lowest filter bits.
// - Byte read returns only the 8 lowest filter bits.
// - With auto-toggle set, each result read inverts low-bit access.
// - Changing auto-toggle leaves low-bit access alone until next read.
// - One result register per channel; new data sets ready flag up to the seventh result of a run.
// - Ready flag clears on result read or by software.
// - Format bit: zero offset binary, one two's complement.
// - Full scale codes FFFF/8000/0000 or 7FFF/0000/8000.
// - Single-conversion and group bits select one of four modes.
// - Channel with group clear after grouped channels is group master.
// - Ungrouped single mode converts once, then hardware clears start.
// - Ungrouped continuous mode converts until software clears start.
// - Clearing start stops, powers down, clears filter at once.
// - Delay setting zero withholds ready until fourth conversion.
// - New result before previous one was read flags overrun up to the seventh result of a run.
`timescale 1ns/10ps
`default_nettype none
`include "sdd_defs.vh"

module sdd_top #(
    parameter NUM_CH = 3,
    parameter SEL_W = 2
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Modulator pins
    input wire ext_mod_clk,
    input wire [NUM_CH-1:0] mod_bit,
    // Modulator clock and ratio
    input wire modulator_clock_source,
    input wire [1:0] modulator_clock_divider,
    input wire [1:0] oversampling_ratio_select,
    // Per-channel configuration
    input wire [NUM_CH-1:0] single_conversion_select,
    input wire [NUM_CH-1:0] group_with_next_channel,
    input wire [NUM_CH-1:0] result_format_select,
    input wire [NUM_CH-1:0] low_bits_auto_toggle,
    input wire [2*NUM_CH-1:0] interrupt_delay_select,
    // Software strobes
    input wire [NUM_CH-1:0] start_set,
    input wire [NUM_CH-1:0] start_clr,
    input wire [NUM_CH-1:0] lsbacc_wr,
    input wire [NUM_CH-1:0] lsbacc_wdata,
    input wire [NUM_CH-1:0] flag_clr,
    input wire [NUM_CH-1:0] overrun_clr,
    // Result read port
    input wire rd_en,
    input wire [SEL_W-1:0] rd_sel,
    input wire rd_byte,
    output reg [15:0] rd_data_q,
    output reg rd_valid_q,
    // Status
    output reg [NUM_CH-1:0] conversion_start_bit_q,
    output reg [NUM_CH-1:0] low_bits_access_q,
    output reg [NUM_CH-1:0] result_ready_flag_q,
    output reg [NUM_CH-1:0] result_overrun_flag_q,
    output reg [NUM_CH-1:0] channel_power_q
);

// ==========================================================================
// Modulator clock
// ==========================================================================
wire ext_clk_lvl;
wire [NUM_CH-1:0] bit_lvl;
reg ext_clk_prev_q;
reg [2:0] div_q;
reg mod_tick_q;
wire src_pulse;
wire [2:0] div_mask;
wire [7:0] phase_last;

sdd_sync3 #(.W(1)) u_clk_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(ext_mod_clk),
    .q(ext_clk_lvl)
);

sdd_sync3 #(.W(NUM_CH)) u_bit_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(mod_bit),
    .q(bit_lvl)
);

assign src_pulse = modulator_clock_source ? (ext_clk_lvl & ~ext_clk_prev_q) : 1'b1;
assign div_mask = (3'h1 << modulator_clock_divider) - 3'h1;
assign phase_last = `SDD_PHASE_FULL >> oversampling_ratio_select;

always @(posedge sys_clk) begin
    if (!rst_n) begin
        ext_clk_prev_q <= `SDD_RST_BIT;
        div_q <= `SDD_RST_DIV;
        mod_tick_q <= `SDD_RST_BIT;
    end else begin
        ext_clk_prev_q <= ext_clk_lvl;
        mod_tick_q <= src_pulse && ((div_q & div_mask) == div_mask);
        if (src_pulse) begin
            div_q <= div_q + 3'h1;
        end
    end
end

// ==========================================================================
// Channels
// ==========================================================================
reg [NUM_CH-1:0] sc_prev_q;
wire [NUM_CH-1:0] own_dec;
wire [NUM_CH-1:0] rd_hit;
wire [`SDD_RES_W*NUM_CH-1:0] res_flat;

genvar gi;
generate
for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
    wire grp_eff;
    wire run;
    wire dec_i;
    wire [`SDD_RES_W-1:0] flt_out;
    wire flt_vld;
    wire [2:0] thr;
    wire counted;
    reg m_sc;
    reg m_sc_prev;
    reg m_dec;
    reg found;
    reg [7:0] phase_q;
    reg synced_q;
    reg [2:0] cnt_q;
    reg unread_q;
    reg [`SDD_RES_W-1:0] res_q;
    integer j;

    // Last channel cannot group forward
    assign grp_eff = (gi == NUM_CH - 1) ? 1'b0 : group_with_next_channel[gi];

    // Master is the first channel above this one with group clear
    always @* begin
        m_sc = 1'b0;
        m_sc_prev = 1'b0;
        m_dec = 1'b0;
        found = 1'b0;
        for (j = gi + 1; j < NUM_CH; j = j + 1) begin
            if (!found && !(group_with_next_channel[j] && j != NUM_CH - 1)) begin
                m_sc = conversion_start_bit_q[j];
                m_sc_prev = sc_prev_q[j];
                m_dec = own_dec[j];
                found = 1'b1;
            end
        end
    end

    // Members run only in step with a running master
    assign run = conversion_start_bit_q[gi] & (grp_eff ? (m_sc & synced_q) : 1'b1);
    assign own_dec[gi] = mod_tick_q & conversion_start_bit_q[gi] & (phase_q == phase_last);
    assign dec_i = grp_eff ? m_dec : own_dec[gi];
    assign thr = `SDD_DLY_BASE - {1'b0, interrupt_delay_select[2*gi +: 2]};
    assign counted = flt_vld && ((cnt_q + 3'h1) >= thr);
    assign rd_hit[gi] = rd_en && (rd_sel == gi);
    assign res_flat[`SDD_RES_W*gi +: `SDD_RES_W] = res_q;

    sdd_sinc3 u_flt (
        .clk(sys_clk),
        .rst_n(rst_n),
        .clear(~run),
        .tick(mod_tick_q & run),
        .dec(dec_i & run),
        .osr_code(oversampling_ratio_select),
        .bit_in(bit_lvl[gi]),
        .out_q(flt_out),
        .out_vld_q(flt_vld)
    );

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            phase_q <= `SDD_RST_PHASE;
            synced_q <= `SDD_RST_BIT;
            cnt_q <= `SDD_RST_CNT;
            unread_q <= `SDD_RST_BIT;
            res_q <= `SDD_RST_RES;
            sc_prev_q[gi] <= `SDD_RST_BIT;
            conversion_start_bit_q[gi] <= `SDD_RST_BIT;
            low_bits_access_q[gi] <= `SDD_RST_BIT;
            result_ready_flag_q[gi] <= `SDD_RST_BIT;
            result_overrun_flag_q[gi] <= `SDD_RST_BIT;
            channel_power_q[gi] <= `SDD_RST_BIT;
        end else begin
            sc_prev_q[gi] <= conversion_start_bit_q[gi];
            channel_power_q[gi] <= run;
            if (!conversion_start_bit_q[gi] || (mod_tick_q && phase_q == phase_last)) begin
                phase_q <= `SDD_RST_PHASE;
            end else if (mod_tick_q) begin
                phase_q <= phase_q + 8'h01;
            end
            // Late joiners wait for the master's next boundary
            if (!conversion_start_bit_q[gi]) begin
                synced_q <= 1'b0;
            end else if (m_dec) begin
                synced_q <= 1'b1;
            end
            if (!run) begin
                cnt_q <= `SDD_RST_CNT;
            end else if (flt_vld && cnt_q != `SDD_CNT_MAX) begin
                cnt_q <= cnt_q + 3'h1;
            end
            if (flt_vld) begin
                res_q <= result_format_select[gi] ? (flt_out ^ `SDD_TC_FLIP) : flt_out;
            end
            // Start bit: hardware completion, then master edges, then software
            if (counted && single_conversion_select[gi]) begin
                conversion_start_bit_q[gi] <= 1'b0;
            end else if (grp_eff && m_sc && !m_sc_prev) begin
                conversion_start_bit_q[gi] <= 1'b1;
            end else if (grp_eff && !m_sc && m_sc_prev) begin
                conversion_start_bit_q[gi] <= 1'b0;
            end
            if (start_clr[gi]) begin
                conversion_start_bit_q[gi] <= 1'b0;
            end
            if (start_set[gi]) begin
                conversion_start_bit_q[gi] <= 1'b1;
            end
            if (lsbacc_wr[gi]) begin
                low_bits_access_q[gi] <= lsbacc_wdata[gi];
            end else if (rd_hit[gi] && low_bits_auto_toggle[gi]) begin
                low_bits_access_q[gi] <= ~low_bits_access_q[gi];
            end
            // Set wins over clear for every flag
            if (counted) begin
                result_ready_flag_q[gi] <= 1'b1;
            end else if (rd_hit[gi] || flag_clr[gi]) begin
                result_ready_flag_q[gi] <= 1'b0;
            end
            if (counted) begin
                unread_q <= 1'b1;
            end else if (rd_hit[gi]) begin
                unread_q <= 1'b0;
            end
            if (counted && unread_q) begin
                result_overrun_flag_q[gi] <= 1'b1;
            end else if (overrun_clr[gi]) begin
                result_overrun_flag_q[gi] <= 1'b0;
            end
        end
    end
end
endgenerate

// ==========================================================================
// Result read path
// ==========================================================================
wire [`SDD_RES_W-1:0] rd_res;
wire rd_lsb;
wire rd_ok;
wire osr_min;

// Saturation would otherwise leak a one into the unused ratio-32 LSB
assign osr_min = (oversampling_ratio_select == `SDD_OSR_32);
// Out-of-range channel numbers read zero
assign rd_ok = (rd_sel < NUM_CH);
assign rd_res = rd_ok ? res_flat[`SDD_RES_W*rd_sel +: `SDD_RES_W] : `SDD_RST_RES;
assign rd_lsb = rd_ok ? low_bits_access_q[rd_sel] : 1'b0;

always @(posedge sys_clk) begin
    if (!rst_n) begin
        rd_data_q <= `SDD_RST_RD;
        rd_valid_q <= `SDD_RST_BIT;
    end else begin
        rd_valid_q <= rd_en;
        if (rd_en) begin
            if (rd_byte) begin
                rd_data_q <= {`SDD_BYTE_PAD, rd_res[7:0]};
            end else if (rd_lsb && oversampling_ratio_select != `SDD_OSR_256) begin
                rd_data_q <= {rd_res[15:1], rd_res[0] & ~osr_min};
            end else begin
                rd_data_q <= {rd_res[`SDD_WIN_HI:`SDD_WIN_LO+1], rd_res[`SDD_WIN_LO] & ~osr_min};
            end
        end
    end
end

endmodule // sdd_top

`default_nettype wire

/* rtl/sdd_defs.vh */
`ifndef SDD_DEFS_VH
`define SDD_DEFS_VH

// ==========================================================================
// Oversampling ratio codes
// ==========================================================================
`define SDD_OSR_256 2'h0
`define SDD_OSR_128 2'h1
`define SDD_OSR_64 2'h2
`define SDD_OSR_32 2'h3

// ==========================================================================
// Filter and result layout
// ==========================================================================
`define SDD_RES_W 24
`define SDD_ACC_W 25
`define SDD_SHIFT_STEP 2'h3
`define SDD_PHASE_FULL 8'hff
`define SDD_TC_FLIP 24'h80_0000
`define SDD_SAT_VAL 24'hff_ffff
`define SDD_WIN_HI 23
`define SDD_WIN_LO 8
`define SDD_BYTE_PAD 8'h00

// ==========================================================================
// Settling delay and reset values
// ==========================================================================
`define SDD_DLY_BASE 3'h4
`define SDD_CNT_MAX 3'h7
`define SDD_RST_BIT 1'b0
`define SDD_RST_RES 24'h00_0000
`define SDD_RST_RD 16'h0000
`define SDD_RST_PHASE 8'h00
`define SDD_RST_DIV 3'h0
`define SDD_RST_CNT 3'h0

`endif

/* rtl/sdd_sync3.v */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Three-stage pin synchroniser; output moves when stages two and three agree
// ==========================================================================
module sdd_sync3 #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pin side
    input wire [W-1:0] d,
    // Filtered level
    output reg [W-1:0] q
);

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;

always @(posedge clk) begin
    if (!rst_n) begin
        s1_q <= {W{1'b0}};
        s2_q <= {W{1'b0}};
        s3_q <= {W{1'b0}};
        q <= {W{1'b0}};
    end else begin
        s1_q <= d;
        s2_q <= s1_q;
        s3_q <= s2_q;
        q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
    end
end

endmodule // sdd_sync3

`default_nettype wire

/* rtl/sdd_sinc3.v */
`timescale 1ns/10ps
`default_nettype none
`include "sdd_defs.vh"

// ==========================================================================
// Third-order comb decimator for a one-bit stream
// ==========================================================================
module sdd_sinc3 (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire clear,
    input wire tick,
    input wire dec,
    input wire [1:0] osr_code,
    // Stream in
    input wire bit_in,
    // Top-aligned result
    output reg [`SDD_RES_W-1:0] out_q,
    output reg out_vld_q
);

reg [`SDD_ACC_W-1:0] i1_q;
reg [`SDD_ACC_W-1:0] i2_q;
reg [`SDD_ACC_W-1:0] i3_q;
reg [`SDD_ACC_W-1:0] d1_q;
reg [`SDD_ACC_W-1:0] d2_q;
reg [`SDD_ACC_W-1:0] d3_q;
wire [`SDD_ACC_W-1:0] c1;
wire [`SDD_ACC_W-1:0] c2;
wire [`SDD_ACC_W-1:0] c3;
wire [3:0] shamt;
wire [33:0] scaled;

// Wrapping integrators are exact as long as the comb takes modular differences
assign c1 = i3_q - d1_q;
assign c2 = c1 - d2_q;
assign c3 = c2 - d3_q;
// Smaller ratios give fewer bits; shift them to the top of the word
assign shamt = {2'b00, osr_code} * {2'b00, `SDD_SHIFT_STEP};
assign scaled = {9'h000, c3} << shamt;

always @(posedge clk) begin
    if (!rst_n || clear) begin
        i1_q <= {`SDD_ACC_W{1'b0}};
        i2_q <= {`SDD_ACC_W{1'b0}};
        i3_q <= {`SDD_ACC_W{1'b0}};
        d1_q <= {`SDD_ACC_W{1'b0}};
        d2_q <= {`SDD_ACC_W{1'b0}};
        d3_q <= {`SDD_ACC_W{1'b0}};
        out_q <= `SDD_RST_RES;
        out_vld_q <= `SDD_RST_BIT;
    end else begin
        out_vld_q <= dec;
        if (tick) begin
            i1_q <= i1_q + {{(`SDD_ACC_W-1){1'b0}}, bit_in};
            i2_q <= i2_q + i1_q;
            i3_q <= i3_q + i2_q;
        end
        if (dec) begin
            d1_q <= i3_q;
            d2_q <= c1;
            d3_q <= c2;
            // Exact full scale would wrap to zero, so it saturates
            if (|scaled[33:24]) begin
                out_q <= `SDD_SAT_VAL;
            end else begin
                out_q <= scaled[23:0];
            end
        end
    end
end

endmodule // sdd_sinc3

`default_nettype wire

/* tb/sdd_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Read port checks and port checks on channel 0
// ==========================================================================
module sdd_props #(
    parameter NUM_CH = 3,
    parameter SEL_W = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Configuration and strobes
    input wire logic [NUM_CH-1:0] single_conversion_select,
    input wire logic [NUM_CH-1:0] group_with_next_channel,
    input wire logic [NUM_CH-1:0] low_bits_auto_toggle,
    input wire logic [NUM_CH-1:0] start_set,
    input wire logic [NUM_CH-1:0] start_clr,
    input wire logic [NUM_CH-1:0] lsbacc_wr,
    input wire logic rd_en,
    input wire logic [SEL_W-1:0] rd_sel,
    // Outputs
    input wire logic [15:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic [NUM_CH-1:0] conversion_start_bit_q,
    input wire logic [NUM_CH-1:0] low_bits_access_q,
    input wire logic [NUM_CH-1:0] result_ready_flag_q,
    input wire logic [NUM_CH-1:0] result_overrun_flag_q,
    input wire logic [NUM_CH-1:0] channel_power_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic rd0;
    wire logic solo0;
    assign rd0 = rd_en && rd_sel == 0;
    assign solo0 = !group_with_next_channel[0];
    sequence s_stop;
        !conversion_start_bit_q[0] ##1 !channel_power_q[0];
    endsequence
    property p_rd_answer;
        rd_en |=> rd_valid_q;
    endproperty
    property p_rd_quiet;
        !rd_en |=> !rd_valid_q;
    endproperty
    property p_bad_sel;
        rd_en && rd_sel >= NUM_CH |=> rd_data_q == 16'h0000;
    endproperty
    property p_flag_read;
        rd0 && !channel_power_q[0] |=> !result_ready_flag_q[0];
    endproperty
    property p_toggle;
        rd0 && low_bits_auto_toggle[0] && !lsbacc_wr[0]
            |=> low_bits_access_q[0] != $past(low_bits_access_q[0]);
    endproperty
    property p_hold;
        !rd0 && !lsbacc_wr[0] |=> $stable(low_bits_access_q[0]);
    endproperty
    property p_start;
        start_set[0] |=> conversion_start_bit_q[0];
    endproperty
    property p_stop;
        start_clr[0] && !start_set[0] && solo0 |=> s_stop;
    endproperty
    property p_single_done;
        $fell(conversion_start_bit_q[0]) && !$past(start_clr[0]) && solo0
            |-> result_ready_flag_q[0];
    endproperty
    property p_continuous;
        !single_conversion_select[0] && conversion_start_bit_q[0] && !start_clr[0] && solo0
            |=> conversion_start_bit_q[0];
    endproperty
    property p_overrun;
        $rose(result_overrun_flag_q[0]) |-> $past(result_ready_flag_q[0]);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
    a_bad_sel: assert property (p_bad_sel) else $error("bad select data");
    a_flag_read: assert property (p_flag_read) else $error("flag kept on read");
    a_toggle: assert property (p_toggle) else $error("low access not toggled");
    a_hold: assert property (p_hold) else $error("low access moved");
    a_start: assert property (p_start) else $error("start bit not set");
    a_stop: assert property (p_stop) else $error("stop not prompt");
    a_single_done: assert property (p_single_done) else $error("done without flag");
    a_continuous: assert property (p_continuous) else $error("continuous stopped");
    a_overrun: assert property (p_overrun) else $error("overrun without flag");
endmodule // sdd_props

bind sdd_top sdd_props #(.NUM_CH(NUM_CH), .SEL_W(SEL_W)) i_props (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .single_conversion_select(single_conversion_select),
    .group_with_next_channel(group_with_next_channel),
    .low_bits_auto_toggle(low_bits_auto_toggle),
    .start_set(start_set), .start_clr(start_clr), .lsbacc_wr(lsbacc_wr),
    .rd_en(rd_en), .rd_sel(rd_sel), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .conversion_start_bit_q(conversion_start_bit_q), .low_bits_access_q(low_bits_access_q),
    .result_ready_flag_q(result_ready_flag_q), .result_overrun_flag_q(result_overrun_flag_q),
    .channel_power_q(channel_power_q)
);
`default_nettype wire

/* tb/sdd_mod_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Modulator stand-in: full-scale streams and a slow external clock
// ==========================================================================
module sdd_mod_model #(
    parameter NUM_CH = 3
) (
    // Clock
    input wire logic sys_clk,
    // Per channel: 0 all zeros, 1 all ones
    input wire logic [NUM_CH-1:0] level_sel,
    // Modulator pins
    output wire logic ext_mod_clk,
    output logic [NUM_CH-1:0] mod_bit
);
    logic [1:0] div_q = 2'h0;
    assign ext_mod_clk = div_q[1];
    always @(posedge sys_clk) begin
        div_q <= div_q + 2'h1;
        mod_bit <= level_sel;
    end
endmodule // sdd_mod_model
`default_nettype wire

/* tb/test_sdd_top.sv */
`timescale 1ns/10ps
`default_nettype none
module test_sdd_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, src = 1'b0, rd_en = 1'b0, rd_byte = 1'b0;
    logic [1:0] div = 2'h0, oversampling_ratio = 2'h2, rd_sel = 2'h0;
    logic [2:0] lvl = 3'h0, sngl = 3'h7, grp = 3'h0, fmt = 3'h0, tog = 3'h0;
    logic [2:0] s_set = 3'h0, s_clr = 3'h0, lw = 3'h0, lwd = 3'h0, f_clr = 3'h0, o_clr = 3'h0;
    logic [5:0] dly = 6'h00;
    logic [15:0] hi_tab [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
    wire logic ext_clk, rd_valid;
    wire logic [2:0] mbit, sc, lsba, rdy, ovr, pwr;
    wire logic [15:0] rd_data;
    int bad_count = 0, num_checks = 0, cyc = 0, t0;
    always #2 sys_clk = ~sys_clk;
    sdd_mod_model #(.NUM_CH(3)) i_mod (.sys_clk(sys_clk), .level_sel(lvl),
        .ext_mod_clk(ext_clk), .mod_bit(mbit));
    sdd_top #(.NUM_CH(3), .SEL_W(2)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .ext_mod_clk(ext_clk), .mod_bit(mbit), .modulator_clock_source(src),
        .modulator_clock_divider(div), .oversampling_ratio_select(oversampling_ratio),
        .single_conversion_select(sngl), .group_with_next_channel(grp),
        .result_format_select(fmt), .low_bits_auto_toggle(tog), .interrupt_delay_select(dly),
        .start_set(s_set), .start_clr(s_clr), .lsbacc_wr(lw), .lsbacc_wdata(lwd),
        .flag_clr(f_clr), .overrun_clr(o_clr), .rd_en(rd_en), .rd_sel(rd_sel),
        .rd_byte(rd_byte), .rd_data_q(rd_data), .rd_valid_q(rd_valid),
        .conversion_start_bit_q(sc), .low_bits_access_q(lsba), .result_ready_flag_q(rdy),
        .result_overrun_flag_q(ovr), .channel_power_q(pwr));
    // ==========================================================================
    // Access tasks
    // ==========================================================================
    task automatic end_of_test;
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bit_chk(input string what, input logic seen, input logic exp);
        chk(what, {15'h0000, seen}, {15'h0000, exp});
    endtask
    // Samples at the edge itself, so flops show last cycle's value
    task automatic rd(input logic [1:0] sel, input logic byt, input logic [15:0] exp);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        rd_sel <= sel;
        rd_byte <= byt;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(posedge sys_clk);
        chk("rd_data", rd_data, exp);
    endtask
    task automatic go(input int ch, input logic on);
        @(posedge sys_clk);
        s_set <= on ? 3'h1 << ch : 3'h0;
        s_clr <= on ? 3'h0 : 3'h1 << ch;
        @(posedge sys_clk);
        s_set <= 3'h0;
        s_clr <= 3'h0;
    endtask
    task automatic wait_rdy;
        t0 = cyc;
        do @(posedge sys_clk); while (rdy[0] !== 1'b1 && cyc - t0 < 3000);
    endtask
    // ==========================================================================
    // Timeout
    // ==========================================================================
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 9000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ==========================================================================
    // Scenarios
    // ==========================================================================
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int k = 0; k < 4; k++) begin
            fmt[0] <= k[1];
            lvl[0] <= k[0];
            go(0, 1'b1);
            wait_rdy();
            bit_chk("delay", cyc - t0 >= 250 && cyc - t0 <= 275, 1'b1);
            bit_chk("start", sc[0], 1'b0);
            tog[0] <= 1'b1;
            @(posedge sys_clk);
            bit_chk("lsbacc", lsba[0], 1'b0);
            rd(2'h0, 1'b0, hi_tab[k]);
            bit_chk("lsbacc", lsba[0], 1'b1);
            bit_chk("ready", rdy[0], 1'b0);
            rd(2'h0, 1'b0, k[0] ? 16'hffff : 16'h0000);
            rd(2'h0, 1'b1, k[0] ? 16'h00ff : 16'h0000);
            tog[0] <= 1'b0;
            lw[0] <= 1'b1;
            lwd[0] <= k == 3;
            @(posedge sys_clk);
            lw[0] <= 1'b0;
        end
        // Ratio 256 with low access still shows the top bits
        oversampling_ratio <= 2'h0;
        go(0, 1'b1);
        wait_rdy();
        rd(2'h0, 1'b0, 16'h7fff);
        // Ratio 32 on the external clock halved
        oversampling_ratio <= 2'h3;
        src <= 1'b1;
        div <= 2'h1;
        fmt[0] <= 1'b0;
        lw[0] <= 1'b1;
        lwd[0] <= 1'b0;
        go(0, 1'b1);
        lw[0] <= 1'b0;
        wait_rdy();
        bit_chk("rate", cyc - t0 >= 1010 && cyc - t0 <= 1070, 1'b1);
        rd(2'h0, 1'b0, 16'hfffe);
        // Continuous run left unread, then stopped
        src <= 1'b0;
        div <= 2'h0;
        sngl[0] <= 1'b0;
        go(0, 1'b1);
        wait_rdy();
        repeat (40) @(posedge sys_clk);
        bit_chk("overrun", ovr[0], 1'b1);
        bit_chk("start", sc[0], 1'b1);
        rd(2'h0, 1'b0, 16'hfffe);
        go(0, 1'b0);
        f_clr[0] <= 1'b1;
        o_clr[0] <= 1'b1;
        repeat (2) @(posedge sys_clk);
        f_clr[0] <= 1'b0;
        o_clr[0] <= 1'b0;
        bit_chk("power", pwr[0], 1'b0);
        bit_chk("ready", rdy[0], 1'b0);
        bit_chk("overrun", ovr[0], 1'b0);
        rd(2'h3, 1'b0, 16'h0000);
        // Channel 0 follows channel 1 as group master
        grp[0] <= 1'b1;
        sngl[1] <= 1'b0;
        go(1, 1'b1);
        repeat (3) @(posedge sys_clk);
        bit_chk("member", sc[0], 1'b1);
        go(1, 1'b0);
        repeat (3) @(posedge sys_clk);
        bit_chk("member", sc[0], 1'b0);
        end_of_test();
    end
endmodule // test_sdd_top
`default_nettype wire
